// ### hw/ispi_port.sv
// Serial register port of the impact sensor: frame decoder, shifters, register bank.
// Assumes pins arrive asynchronous to mclk and the serial clock is at most mclk/8.
module ispi_port
    import ispi_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    input wire logic core_we,
    input wire logic [IDX_W-1:0] core_idx,
    input wire logic [REG_W-1:0] core_data,
    output logic wr_fifo_ready,
    output logic host_wr_valid,
    output logic [ADDR_W-1:0] host_wr_addr,
    output logic [BYTE_W-1:0] host_wr_data
);

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:1];
    endfunction

    function automatic logic [1:0] lane_of(input logic [ADDR_W-1:0] a);
        return a[0] ? BE_UPPER : BE_LOWER;
    endfunction

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    logic [2:0] pins;
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic [2:0] flt_r;
    logic [2:0] flt_nxt;
    logic [2:0] fltd_r;

    assign pins = {cs_n, sclk, din};

    // A level only counts once two late stages agree, which rejects a runt pulse
    always_comb
    begin
        flt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_r <= PIN_RST;
            s2_r <= PIN_RST;
            s3_r <= PIN_RST;
            flt_r <= PIN_RST;
            fltd_r <= PIN_RST;
        end
        else
        begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            flt_r <= flt_nxt;
            fltd_r <= flt_r;
        end
    end

    logic cs_act;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic din_s;

    assign cs_act = !flt_r[PIN_CS];
    assign cs_fall = fltd_r[PIN_CS] && !flt_r[PIN_CS];
    assign cs_rise = !fltd_r[PIN_CS] && flt_r[PIN_CS];
    assign sclk_rise = !fltd_r[PIN_SCLK] && flt_r[PIN_SCLK];
    assign sclk_fall = fltd_r[PIN_SCLK] && !flt_r[PIN_SCLK];
    assign din_s = flt_r[PIN_DIN];

    // ----------------------------------------------------------------
    // Write path and register bank
    // ----------------------------------------------------------------
    ispi_mem_if mbus ();

    logic fifo_push;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [WR_W-1:0] fifo_out_data;
    logic [WR_W-1:0] push_data;
    logic rd_req;
    logic [ADDR_W-1:0] drain_addr;
    logic [BYTE_W-1:0] drain_byte;
    ispi_state_t state_r;
    ispi_state_t state_nxt;
    logic [4:0] bit_cnt_r;
    logic [4:0] bit_cnt_nxt;
    logic [REG_W-1:0] rx_r;
    logic [REG_W-1:0] rx_nxt;
    logic [REG_W-1:0] tx_r;
    logic [REG_W-1:0] tx_nxt;
    logic [1:0] op;

    ispi_fifo #(
        .WIDTH(WR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .in_valid(fifo_push),
        .in_ready(wr_fifo_ready),
        .in_data(push_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    ispi_mem #(
        .DEPTH(REG_COUNT)
    ) u_mem (
        .mclk(mclk),
        .reset_n(reset_n),
        .mp(mbus.mem)
    );

    assign drain_addr = fifo_out_data[WR_W-1:BYTE_W];
    assign drain_byte = fifo_out_data[BYTE_W-1:0];
    // Core updates win; host writes wait in the FIFO, and one arriving while it is full is dropped
    assign fifo_out_ready = !core_we;

    always_comb
    begin
        mbus.we = core_we || fifo_out_valid;
        mbus.wbe = BE_WORD;
        mbus.widx = core_idx;
        mbus.wdata = core_data;
        if (!core_we)
        begin
            mbus.wbe = lane_of(drain_addr);
            mbus.widx = idx_of(drain_addr);
            mbus.wdata = {drain_byte, drain_byte};
        end
        mbus.re = rd_req;
        mbus.ridx = idx_of(rx_r[ADDR_HI:ADDR_LO]);
    end

    // ----------------------------------------------------------------
    // Committed host writes reported to the core
    // ----------------------------------------------------------------
    logic hw_valid_nxt;
    logic [ADDR_W-1:0] hw_addr_nxt;
    logic [BYTE_W-1:0] hw_data_nxt;

    always_comb
    begin
        hw_valid_nxt = fifo_out_valid && fifo_out_ready;
        hw_addr_nxt = host_wr_addr;
        hw_data_nxt = host_wr_data;
        if (hw_valid_nxt)
        begin
            hw_addr_nxt = drain_addr;
            hw_data_nxt = drain_byte;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            host_wr_valid <= 1'b0;
            host_wr_addr <= '0;
            host_wr_data <= '0;
        end
        else
        begin
            host_wr_valid <= hw_valid_nxt;
            host_wr_addr <= hw_addr_nxt;
            host_wr_data <= hw_data_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Frame controller
    // ----------------------------------------------------------------
    assign op = rx_r[OP_HI:OP_LO];
    assign push_data = rx_r[ADDR_HI:0];

    always_comb
    begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        fifo_push = 1'b0;
        rd_req = 1'b0;
        unique case (state_r)
            ST_IDLE:
            begin
                // Deselected: clock and data are not even looked at
                if (cs_fall)
                begin
                    state_nxt = ST_FRAME;
                    bit_cnt_nxt = '0;
                end
            end
            ST_FRAME:
            begin
                if (cs_rise)
                begin
                    state_nxt = ST_IDLE;
                    tx_nxt = TX_IDLE;
                    if (bit_cnt_r == FRAME_BITS)
                    begin
                        fifo_push = (op == OP_WRITE);
                        rd_req = (op == OP_READ);
                        if (op == OP_READ)
                            state_nxt = ST_FETCH;
                    end
                end
                else
                begin
                    if (sclk_rise)
                    begin
                        rx_nxt = {rx_r[REG_W-2:0], din_s};
                        if (bit_cnt_r != CNT_OVER)
                            bit_cnt_nxt = bit_cnt_r + 5'h01;
                    end
                    // Bit 15 went out at select fall; leading fall in mode 3 must not shift
                    if (sclk_fall && bit_cnt_r != '0)
                        tx_nxt = {tx_r[REG_W-2:0], 1'b0};
                end
            end
            ST_FETCH:
            begin
                tx_nxt = mbus.rdata;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_IDLE;
            bit_cnt_r <= '0;
            rx_r <= '0;
            tx_r <= TX_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
        end
    end

    assign dout = tx_r[REG_W-1];
    assign dout_oe = cs_act;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    oe_idle_a: assert property (flt_r[PIN_CS] |-> !dout_oe)
        else $error("serial output driven while deselected");
    oe_frame_a: assert property ($fell(flt_r[PIN_CS]) |-> dout_oe throughout cs_act [*2])
        else $error("serial output not driven in frame");
    idle_hold_a: assert property (flt_r[PIN_CS] && fltd_r[PIN_CS] |=> $stable(rx_r))
        else $error("shift register moved while deselected");
    full_frame_a: assert property ((fifo_push || rd_req) |-> bit_cnt_r == 5'h10)
        else $error("request from a frame not sixteen bits long");
    short_drop_a: assert property (cs_rise && bit_cnt_r != 5'h10 |-> !fifo_push && !rd_req)
        else $error("partial frame acted upon");
    write_op_a: assert property (fifo_push |-> rx_r[15:14] == 2'h2 && push_data == rx_r[13:0])
        else $error("write pushed for wrong opcode");
    read_load_a: assert property (rd_req |-> ##2 tx_r == $past(mbus.rdata))
        else $error("read word not loaded for next frame");
    shift_out_a: assert property (sclk_fall && state_r == ST_FRAME && !cs_rise
        && bit_cnt_r != 5'h00 |=> tx_r == {$past(tx_r[14:0]), 1'b0})
        else $error("output word did not shift on falling clock");
    lane_sel_a: assert property (fifo_out_valid && !core_we |-> mbus.wbe != 2'h3)
        else $error("host write touched both bytes");

    write_frame_c: cover property (fifo_push);
    read_frame_c: cover property (rd_req ##[1:1000] cs_rise);
    short_frame_c: cover property (cs_rise && bit_cnt_r < 5'h10 && state_r == ST_FRAME);
    fifo_full_c: cover property (!wr_fifo_ready);

endmodule

// ### hw/ispi_pkg.sv
// Shared constants and types of the impact sensor serial register port.
// Assumes a single 20 MHz core clock; all pin timing is recovered by sampling.
package ispi_pkg;

    // ----------------------------------------------------------------
    // Frame and register layout
    // ----------------------------------------------------------------
    localparam int unsigned REG_W = 16;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned IDX_W = 5;
    localparam int unsigned REG_COUNT = 32;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned WR_W = ADDR_W + BYTE_W;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CNT_OVER = 5'h11;
    localparam int unsigned OP_HI = 15;
    localparam int unsigned OP_LO = 14;
    localparam int unsigned ADDR_HI = 13;
    localparam int unsigned ADDR_LO = 8;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] BE_UPPER = 2'h2;
    localparam logic [1:0] BE_LOWER = 2'h1;
    localparam logic [1:0] BE_WORD = 2'h3;
    localparam logic [15:0] TX_IDLE = 16'h0000;

    // ----------------------------------------------------------------
    // Pin sampling: bit positions and idle levels at reset
    // ----------------------------------------------------------------
    localparam int unsigned PIN_DIN = 0;
    localparam int unsigned PIN_SCLK = 1;
    localparam int unsigned PIN_CS = 2;
    localparam logic [2:0] PIN_RST = 3'h6;

    typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_FETCH} ispi_state_t;

endpackage

// ### hw/ispi_mem_if.sv
// Port bundle between the frame controller and the register memory.
// Assumes both ends run on the core clock.
interface ispi_mem_if;
    import ispi_pkg::*;
    logic we;
    logic [1:0] wbe;
    logic [IDX_W-1:0] widx;
    logic [REG_W-1:0] wdata;
    logic re;
    logic [IDX_W-1:0] ridx;
    logic [REG_W-1:0] rdata;

    modport ctrl (output we, output wbe, output widx, output wdata, output re, output ridx,
        input rdata);
    modport mem (input we, input wbe, input widx, input wdata, input re, input ridx,
        output rdata);
endinterface

// ### hw/ispi_mem.sv
// Register bank: 16-bit words with per-byte write enables, registered read.
// Assumes the controller resolves write priority before this port.
module ispi_mem
    import ispi_pkg::*;
#(
    parameter int unsigned DEPTH = REG_COUNT
)(
    input wire logic mclk,
    input wire logic reset_n,
    ispi_mem_if.mem mp
);

    logic [REG_W-1:0] rd_word;
    logic [REG_W-1:0] rdata_r;
    logic [REG_W-1:0] rdata_nxt;

    // ----------------------------------------------------------------
    // Byte lanes
    // ----------------------------------------------------------------
    // No reset on the array: contents are loaded by the core after start
    // One array per lane keeps a single writing process for each
    genvar b;
    generate
        for (b = 0; b < 2; b++)
        begin : g_lane
            logic [BYTE_W-1:0] lane_q [DEPTH];
            always_ff @(posedge mclk)
            begin
                if (mp.we && mp.wbe[b])
                    lane_q[mp.widx] <= mp.wdata[b*BYTE_W +: BYTE_W];
            end
            assign rd_word[b*BYTE_W +: BYTE_W] = lane_q[mp.ridx];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (mp.re)
            rdata_nxt = rd_word;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_r <= TX_IDLE;
        else
            rdata_r <= rdata_nxt;
    end

    assign mp.rdata = rdata_r;

endmodule

// ### hw/ispi_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; the drain side may stall at will.
module ispi_fifo
    import ispi_pkg::*;
#(
    parameter int unsigned WIDTH = WR_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
)(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] buf_r [DEPTH];
    logic [PW:0] wr_ptr_r;
    logic [PW:0] wr_ptr_nxt;
    logic [PW:0] rd_ptr_r;
    logic [PW:0] rd_ptr_nxt;
    logic push;
    logic pop;
    logic full;
    logic empty;

    // ----------------------------------------------------------------
    // Pointers
    // ----------------------------------------------------------------
    always_comb
    begin
        empty = (wr_ptr_r == rd_ptr_r);
        full = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
        in_ready = !full;
        out_valid = !empty;
        push = in_valid && !full;
        pop = out_ready && !empty;
        wr_ptr_nxt = wr_ptr_r + (PW+1)'(push);
        rd_ptr_nxt = rd_ptr_r + (PW+1)'(pop);
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (push)
            buf_r[wr_ptr_r[PW-1:0]] <= in_data;
    end

    assign out_data = buf_r[rd_ptr_r[PW-1:0]];

    full_block_a: assert property (@(posedge mclk) disable iff (!reset_n)
        full |=> !$changed(wr_ptr_r) || $past(pop))
        else $error("fifo accepted a word while full");

endmodule

// ### dv/ispi_host_model.sv
// Host-side serial master model: mode 3 frames on a 400 ns link clock.
// Assumes the port drives dout only while dout_oe is high.
module ispi_host_model (
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Line level and idle state
    // ----------------------------------------------------------------
    logic line;
    assign line = dout_oe ? dout : 1'bz;

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end

    // ----------------------------------------------------------------
    // Frame and deselected noise
    // ----------------------------------------------------------------
    // Any nclk other than 16 makes a malformed frame on purpose
    task automatic frame(input logic [15:0] tx, input int nclk, output logic [15:0] rx,
        output int oe_err);
        int i;
        rx = 16'h0000;
        oe_err = 0;
        cs_n = 1'b0;
        #400;
        for (i = 0; i < nclk; i++)
        begin
            sclk = 1'b0;
            din = (i < 16) ? tx[15 - i] : 1'b0;
            #200;
            sclk = 1'b1;
            // Sampled late in the bit: the port's output lags by its pin synchroniser
            #190;
            if (dout_oe !== 1'b1)
                oe_err++;
            rx = {rx[14:0], line};
            #10;
        end
        cs_n = 1'b1;
        din = ~din;
        #600;
    endtask

    task automatic noise(input int n, output int oe_err);
        int i;
        oe_err = 0;
        for (i = 0; i < n; i++)
        begin
            sclk = ~sclk;
            din = ~din;
            #200;
            if (dout_oe !== 1'b0)
                oe_err++;
        end
        sclk = 1'b1;
        #400;
    endtask
endmodule

// ### dv/tb_impact_sensor_spi_register_port.sv
// Self-checking bench of the serial register port with a host model.
// Assumes the design files and the host model are compiled first.
module tb_impact_sensor_spi_register_port
    import ispi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Signals, clock, monitor
    // ----------------------------------------------------------------
    localparam int LIMIT = 20000;
    logic mclk;
    logic reset_n = 1'b0;
    logic cs_n, sclk, din, dout, dout_oe;
    logic core_we = 1'b0;
    logic [IDX_W-1:0] core_idx = '0;
    logic [REG_W-1:0] core_data = '0;
    logic wr_fifo_ready, host_wr_valid;
    logic [ADDR_W-1:0] host_wr_addr;
    logic [BYTE_W-1:0] host_wr_data;
    logic [5:0] last_addr = 6'h00;
    logic [7:0] last_data = 8'h00;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int wr_pulses = 0;

    ispi_port DUT (.mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout), .dout_oe(dout_oe), .core_we(core_we), .core_idx(core_idx),
        .core_data(core_data), .wr_fifo_ready(wr_fifo_ready), .host_wr_valid(host_wr_valid),
        .host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data));
    ispi_host_model host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Watched on the falling edge, where registered outputs have settled
    always @(negedge mclk)
    begin
        cycles++;
        if (host_wr_valid === 1'b1)
        begin
            wr_pulses++;
            last_addr = host_wr_addr;
            last_data = host_wr_data;
        end
        if (cycles == LIMIT)
        begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [15:0] rd(input logic [5:0] a);
        return {OP_READ, a, 8'h00};
    endfunction

    function automatic logic [15:0] wr(input logic [5:0] a, input logic [7:0] d);
        return {OP_WRITE, a, d};
    endfunction

    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        int e;
        host.frame(tx, n, rx, e);
        check("enable in frame", 16'(e), 16'h0000);
    endtask

    task automatic core_wr(input logic [4:0] idx, input logic [15:0] d);
        @(negedge mclk);
        core_we = 1'b1;
        core_idx = idx;
        core_data = d;
        @(negedge mclk);
        core_we = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_read();
        logic [15:0] rx;
        core_wr(5'h05, 16'ha5c3);
        xfer(rd(6'h0b), 16, rx);
        xfer(rd(6'h0a), 16, rx);
        check("upper addr read", rx, 16'ha5c3);
        xfer({2'b01, 6'h0a, 8'h11}, 16, rx);
        check("lower addr read", rx, 16'ha5c3);
        xfer({2'b11, 6'h0a, 8'h11}, 16, rx);
        check("after op 01", rx, 16'h0000);
        xfer(rd(6'h0a), 16, rx);
        check("after op 11", rx, 16'h0000);
        check("no write from 01 11", 16'(wr_pulses), 16'h0000);
        $display("test read done");
    endtask

    task automatic t_write();
        logic [15:0] rx;
        int p;
        core_wr(5'h02, 16'h1234);
        p = wr_pulses;
        xfer(wr(6'h04, 8'h3c), 16, rx);
        check("write count", 16'(wr_pulses - p), 16'h0001);
        check("write byte", {2'b00, last_addr, last_data}, 16'h043c);
        xfer(wr(6'h05, 8'h9e), 16, rx);
        xfer(rd(6'h04), 16, rx);
        check("after write frame", rx, 16'h0000);
        xfer(rd(6'h05), 16, rx);
        check("merged bytes", rx, 16'h9e3c);
        $display("test write done");
    endtask

    task automatic t_short();
        logic [15:0] rx;
        int p;
        p = wr_pulses;
        xfer(rd(6'h04), 16, rx);
        xfer(wr(6'h04, 8'h77), 15, rx);
        xfer(wr(6'h04, 8'h77), 17, rx);
        xfer(rd(6'h04), 16, rx);
        check("after short frames", rx, 16'h0000);
        xfer(rd(6'h04), 16, rx);
        check("reg kept", rx, 16'h9e3c);
        check("short write count", 16'(wr_pulses - p), 16'h0000);
        $display("test short done");
    endtask

    task automatic t_deselect();
        logic [15:0] rx;
        int e;
        int p;
        p = wr_pulses;
        xfer(rd(6'h0a), 16, rx);
        host.noise(40, e);
        check("enable deselected", 16'(e), 16'h0000);
        xfer(rd(6'h0a), 16, rx);
        check("read across noise", rx, 16'ha5c3);
        check("noise write count", 16'(wr_pulses - p), 16'h0000);
        $display("test deselect done");
    endtask

    task automatic t_fifo();
        logic [15:0] rx;
        int p;
        int k;
        core_wr(5'h18, 16'hbeef);
        p = wr_pulses;
        @(negedge mclk);
        // Core writes hold priority, so the host queue cannot drain
        core_we = 1'b1;
        core_idx = 5'h00;
        core_data = 16'hffff;
        for (k = 0; k < 16; k++)
            xfer(wr(6'(6'h10 + k), 8'(8'h40 + k)), 16, rx);
        check("ready when full", 16'(wr_fifo_ready), 16'h0000);
        xfer(wr(6'h30, 8'h55), 16, rx);
        check("stalled count", 16'(wr_pulses - p), 16'h0000);
        @(negedge mclk);
        core_we = 1'b0;
        repeat (60) @(negedge mclk);
        check("drained count", 16'(wr_pulses - p), 16'h0010);
        check("ready when empty", 16'(wr_fifo_ready), 16'h0001);
        xfer(rd(6'h10), 16, rx);
        xfer(rd(6'h30), 16, rx);
        check("queued bytes", rx, 16'h4140);
        xfer(rd(6'h00), 16, rx);
        check("dropped write", rx, 16'hbeef);
        xfer(rd(6'h00), 16, rx);
        check("core word", rx, 16'hffff);
        $display("test fifo done");
    endtask

    task automatic t_reset();
        logic [15:0] rx;
        xfer(rd(6'h0a), 16, rx);
        @(negedge mclk);
        reset_n = 1'b0;
        repeat (5) @(negedge mclk);
        check("enable in reset", 16'(dout_oe), 16'h0000);
        check("valid in reset", 16'(host_wr_valid), 16'h0000);
        check("ready in reset", 16'(wr_fifo_ready), 16'h0001);
        reset_n = 1'b1;
        @(negedge mclk);
        check("write out after reset", {2'b00, host_wr_addr, host_wr_data}, 16'h0000);
        xfer(rd(6'h0a), 16, rx);
        check("pending read cleared", rx, 16'h0000);
        xfer(rd(6'h0a), 16, rx);
        check("bank after reset", rx, 16'ha5c3);
        $display("test reset done");
    endtask

    initial
    begin
        repeat (5) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        check("idle enable", 16'(dout_oe), 16'h0000);
        t_read();
        t_write();
        t_short();
        t_deselect();
        t_fifo();
        t_reset();
        tally_and_finish();
    end
endmodule
